// >>> dpllc_regs.sv
// dpllc_regs: serial-port register bank steering the two synthesizer loops
//
// Function
// - first-stage bypass bit disables and routes around loop
// - second-stage bypass feeds first loop to dividers
// - slope polarity bit sets detector sense, resets zero
// - force-midpoint holds tuning pin at half supply
// - first pump current is 50uA times code plus one
// - first pump code resets to 0x0F, 0.8mA
// - offset enable applies programmed offset, resets zero
// - offset is 0.9 degree per step, resets zero
// - second pump 200uA times code plus one, reset 6
`timescale 1ns/100ps

module dpllc_regs
  import dpllc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        srst_in,
  input  wire logic        spi_sclk_in,
  input  wire logic        spi_cs_n_in,
  input  wire logic        spi_mosi_in,
  output logic             spi_miso_out,
  output logic             spi_miso_oe_n_out,
  output logic             first_stage_bypass_out,
  output logic             second_stage_bypass_out,
  output logic             oscillator_range_sel_out,
  output logic             vcxo_slope_polarity_out,
  output logic             force_mid_tune_out,
  output logic [4:0]       first_stage_pump_current_out,
  output logic             phase_offset_en_out,
  output logic [4:0]       phase_offset_steps_out,
  output logic [4:0]       second_stage_pump_current_out,
  output logic [10:0]      first_stage_pump_ua_out,
  output logic [12:0]      second_stage_pump_ua_out,
  output logic [8:0]       phase_offset_decideg_out
);

  function automatic logic [12:0] pump_ua(input logic [4:0] code, input logic [12:0] step);
    return ({8'h00, code} + 13'h0001) * step;
  endfunction : pump_ua

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: sclk, cs_n, mosi
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic [2:0] pin_prev;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      pin_meta <= 3'h2;
      pin_sync <= 3'h2;
      pin_prev <= 3'h2;
    end else begin
      pin_meta <= {spi_mosi_in, spi_cs_n_in, spi_sclk_in};
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  logic sclk_rise;
  logic sclk_fall;
  logic cs_n_s;
  logic mosi_s;
  assign sclk_rise = pin_sync[0] & ~pin_prev[0];
  assign sclk_fall = ~pin_sync[0] & pin_prev[0];
  assign cs_n_s    = pin_sync[1];
  assign mosi_s    = pin_sync[2];

  ////////////////////////////////////////////////////////////////////////////
  // frame engine and register file
  dpllc_state_type state;
  dpllc_state_type next_state;
  logic [2:0]      cnt;
  logic [2:0]      next_cnt;
  logic [7:0]      shift;
  logic [7:0]      next_shift;
  logic [7:0]      tx;
  logic [7:0]      next_tx;
  logic            read_op;
  logic            next_read_op;
  logic [6:0]      addr;
  logic [6:0]      next_addr;
  logic            next_miso;
  logic            next_oe_n;
  logic            wr_stb;
  logic [7:0]      wr_data;
  logic [7:0]      rd_byte;

  logic            next_bypass1;
  logic            next_bypass2;
  logic            next_osc_sel;
  logic            next_polarity;
  logic            next_force_mid;
  logic [4:0]      next_pump1;
  logic            next_offs_en;
  logic [4:0]      next_offs_steps;
  logic [4:0]      next_pump2;
  logic [10:0]     next_pump1_ua;
  logic [12:0]     next_pump2_ua;
  logic [8:0]      next_offs_deg;

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    if (addr == ADDR_FIRST_LOOP_BYPASS_CTRL) begin
      rd_byte[BIT_FIRST_STAGE_BYPASS] = first_stage_bypass_out;
    end else if (addr == ADDR_SECOND_LOOP_PATH_CTRL) begin
      rd_byte[BIT_SECOND_STAGE_BYPASS]  = second_stage_bypass_out;
      rd_byte[BIT_OSCILLATOR_RANGE_SEL] = oscillator_range_sel_out;
    end else if (addr == ADDR_FIRST_LOOP_TUNING_CTRL) begin
      rd_byte[BIT_VCXO_SLOPE_POLARITY] = vcxo_slope_polarity_out;
      rd_byte[BIT_FORCE_MID_TUNE]      = force_mid_tune_out;
      rd_byte[CODE_MSB:0]              = first_stage_pump_current_out;
    end else if (addr == ADDR_FIRST_LOOP_PHASE_OFFSET) begin
      rd_byte[BIT_PHASE_OFFSET_EN] = phase_offset_en_out;
      rd_byte[CODE_MSB:0]          = phase_offset_steps_out;
    end else if (addr == ADDR_SECOND_LOOP_PUMP_CURRENT) begin
      rd_byte[CODE_MSB:0] = second_stage_pump_current_out;
    end
  end

  always_comb begin
    next_state      = state;
    next_cnt        = cnt;
    next_shift      = shift;
    next_tx         = tx;
    next_read_op    = read_op;
    next_addr       = addr;
    next_miso       = spi_miso_out;
    next_oe_n       = spi_miso_oe_n_out;
    wr_stb          = 1'b0;
    wr_data         = {shift[6:0], mosi_s};
    next_bypass1    = first_stage_bypass_out;
    next_bypass2    = second_stage_bypass_out;
    next_osc_sel    = oscillator_range_sel_out;
    next_polarity   = vcxo_slope_polarity_out;
    next_force_mid  = force_mid_tune_out;
    next_pump1      = first_stage_pump_current_out;
    next_offs_en    = phase_offset_en_out;
    next_offs_steps = phase_offset_steps_out;
    next_pump2      = second_stage_pump_current_out;
    // deasserting select aborts any frame; a partial write never commits
    if (cs_n_s) begin
      next_state = ST_IDLE;
      next_oe_n  = 1'b1;
      next_miso  = 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_CMD;
          next_cnt   = FIRST_BIT;
        end
        ST_CMD: begin
          if (sclk_rise) begin
            next_shift = {shift[6:0], mosi_s};
            next_cnt   = 3'(cnt + 3'h1);
            if (cnt == LAST_BIT) begin
              next_read_op = next_shift[CMD_READ_BIT];
              next_addr    = next_shift[6:0];
              next_state   = ST_DATA;
            end
          end
        end
        ST_DATA: begin
          next_oe_n = ~read_op;
          // shift on falling edge so the host samples on the rising edge
          if (sclk_fall && read_op) begin
            if (cnt == FIRST_BIT) begin
              next_miso = rd_byte[7];
              next_tx   = {rd_byte[6:0], 1'b0};
            end else begin
              next_miso = tx[7];
              next_tx   = {tx[6:0], 1'b0};
            end
          end
          if (sclk_rise) begin
            next_shift = {shift[6:0], mosi_s};
            next_cnt   = 3'(cnt + 3'h1);
            if (cnt == LAST_BIT) begin
              next_state = ST_DONE;
              wr_stb     = ~read_op;
            end
          end
        end
        ST_DONE: begin
          next_state = ST_DONE;
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
    // only defined fields are stored; reserved bits are dropped
    if (wr_stb) begin
      if (addr == ADDR_FIRST_LOOP_BYPASS_CTRL) begin
        next_bypass1 = wr_data[BIT_FIRST_STAGE_BYPASS];
      end else if (addr == ADDR_SECOND_LOOP_PATH_CTRL) begin
        next_bypass2 = wr_data[BIT_SECOND_STAGE_BYPASS];
        next_osc_sel = wr_data[BIT_OSCILLATOR_RANGE_SEL];
      end else if (addr == ADDR_FIRST_LOOP_TUNING_CTRL) begin
        next_polarity  = wr_data[BIT_VCXO_SLOPE_POLARITY];
        next_force_mid = wr_data[BIT_FORCE_MID_TUNE];
        next_pump1     = wr_data[CODE_MSB:0];
      end else if (addr == ADDR_FIRST_LOOP_PHASE_OFFSET) begin
        next_offs_en    = wr_data[BIT_PHASE_OFFSET_EN];
        next_offs_steps = wr_data[CODE_MSB:0];
      end else if (addr == ADDR_SECOND_LOOP_PUMP_CURRENT) begin
        next_pump2 = wr_data[CODE_MSB:0];
      end
    end
    next_pump1_ua = 11'(pump_ua(next_pump1, FIRST_PUMP_STEP_UA));
    next_pump2_ua = pump_ua(next_pump2, SECOND_PUMP_STEP_UA);
    next_offs_deg = next_offs_en ? 9'({4'h0, next_offs_steps} * OFFSET_STEP_DECIDEG)
                                 : 9'h000;
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      state                         <= ST_IDLE;
      cnt                           <= FIRST_BIT;
      shift                         <= 8'h00;
      tx                            <= 8'h00;
      read_op                       <= 1'b0;
      addr                          <= 7'h00;
      spi_miso_out                  <= 1'b0;
      spi_miso_oe_n_out             <= 1'b1;
      first_stage_bypass_out        <= RST_FIRST_STAGE_BYPASS;
      second_stage_bypass_out       <= RST_SECOND_STAGE_BYPASS;
      oscillator_range_sel_out      <= RST_OSCILLATOR_RANGE_SEL;
      vcxo_slope_polarity_out       <= RST_VCXO_SLOPE_POLARITY;
      force_mid_tune_out            <= RST_FORCE_MID_TUNE;
      first_stage_pump_current_out  <= RST_FIRST_PUMP;
      phase_offset_en_out           <= RST_PHASE_OFFSET_EN;
      phase_offset_steps_out        <= RST_PHASE_OFFSET_STEPS;
      second_stage_pump_current_out <= RST_SECOND_PUMP;
      first_stage_pump_ua_out       <= 11'(pump_ua(RST_FIRST_PUMP, FIRST_PUMP_STEP_UA));
      second_stage_pump_ua_out      <= pump_ua(RST_SECOND_PUMP, SECOND_PUMP_STEP_UA);
      phase_offset_decideg_out      <= 9'h000;
    end else begin
      state                         <= next_state;
      cnt                           <= next_cnt;
      shift                         <= next_shift;
      tx                            <= next_tx;
      read_op                       <= next_read_op;
      addr                          <= next_addr;
      spi_miso_out                  <= next_miso;
      spi_miso_oe_n_out             <= next_oe_n;
      first_stage_bypass_out        <= next_bypass1;
      second_stage_bypass_out       <= next_bypass2;
      oscillator_range_sel_out      <= next_osc_sel;
      vcxo_slope_polarity_out       <= next_polarity;
      force_mid_tune_out            <= next_force_mid;
      first_stage_pump_current_out  <= next_pump1;
      phase_offset_en_out           <= next_offs_en;
      phase_offset_steps_out        <= next_offs_steps;
      second_stage_pump_current_out <= next_pump2;
      first_stage_pump_ua_out       <= next_pump1_ua;
      second_stage_pump_ua_out      <= next_pump2_ua;
      phase_offset_decideg_out      <= next_offs_deg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  property p_reset_defaults;
    $past(srst_in) |-> force_mid_tune_out && !first_stage_bypass_out
      && first_stage_pump_current_out == RST_FIRST_PUMP
      && second_stage_pump_current_out == RST_SECOND_PUMP;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("reset defaults wrong");

  property p_first_bypass_write;
    wr_stb && addr == ADDR_FIRST_LOOP_BYPASS_CTRL
      |=> first_stage_bypass_out == $past(wr_data[BIT_FIRST_STAGE_BYPASS]);
  endproperty
  a_first_bypass_write: assert property (p_first_bypass_write)
    else $error("first-stage bypass not stored");

  property p_second_bypass_write;
    wr_stb && addr == ADDR_SECOND_LOOP_PATH_CTRL
      |=> second_stage_bypass_out == $past(wr_data[BIT_SECOND_STAGE_BYPASS]);
  endproperty
  a_second_bypass_write: assert property (p_second_bypass_write)
    else $error("second-stage bypass not stored");

  property p_tuning_write;
    wr_stb && addr == ADDR_FIRST_LOOP_TUNING_CTRL
      |=> vcxo_slope_polarity_out == $past(wr_data[BIT_VCXO_SLOPE_POLARITY])
       && force_mid_tune_out == $past(wr_data[BIT_FORCE_MID_TUNE]);
  endproperty
  a_tuning_write: assert property (p_tuning_write)
    else $error("tuning control not stored");

  property p_hold_without_write;
    !wr_stb |=> $stable(force_mid_tune_out) && $stable(first_stage_bypass_out);
  endproperty
  a_hold_without_write: assert property (p_hold_without_write)
    else $error("control changed without write");

  property p_pump1_current;
    ##1 first_stage_pump_ua_out == 11'(({6'h00, first_stage_pump_current_out} + 11'h001)
      * 11'h032);
  endproperty
  a_pump1_current: assert property (p_pump1_current)
    else $error("first pump current mismatch");

  property p_pump2_current;
    ##1 second_stage_pump_ua_out == 13'(({8'h00, second_stage_pump_current_out} + 13'h0001)
      * 13'h00C8);
  endproperty
  a_pump2_current: assert property (p_pump2_current)
    else $error("second pump current mismatch");

  property p_offset_gate;
    ##1 phase_offset_decideg_out == (phase_offset_en_out
      ? 9'({4'h0, phase_offset_steps_out} * 9'h009) : 9'h000);
  endproperty
  a_offset_gate: assert property (p_offset_gate)
    else $error("phase offset output mismatch");

  property p_reserved_zero;
    addr == ADDR_FIRST_LOOP_BYPASS_CTRL |-> rd_byte == {7'h00, first_stage_bypass_out};
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved bits not zero");

  c_write_frame:  cover property (wr_stb && addr == ADDR_FIRST_LOOP_TUNING_CTRL);
  c_read_frame:   cover property (state == ST_DATA && read_op && sclk_fall);
  c_mid_released: cover property ($fell(force_mid_tune_out));
  c_abort:        cover property (state == ST_DATA && cs_n_s);

endmodule : dpllc_regs

// >>> dpllc_pkg.sv
// dpllc_pkg: register map, field layout, reset values and frame constants
package dpllc_pkg;

  // register byte addresses
  localparam logic [6:0] ADDR_FIRST_LOOP_BYPASS_CTRL   = 7'h17;
  localparam logic [6:0] ADDR_SECOND_LOOP_PATH_CTRL    = 7'h18;
  localparam logic [6:0] ADDR_FIRST_LOOP_TUNING_CTRL   = 7'h1C;
  localparam logic [6:0] ADDR_FIRST_LOOP_PHASE_OFFSET  = 7'h1D;
  localparam logic [6:0] ADDR_SECOND_LOOP_PUMP_CURRENT = 7'h1E;

  // bit positions
  localparam int BIT_FIRST_STAGE_BYPASS   = 0;
  localparam int BIT_OSCILLATOR_RANGE_SEL = 0;
  localparam int BIT_SECOND_STAGE_BYPASS  = 1;
  localparam int BIT_VCXO_SLOPE_POLARITY  = 7;
  localparam int BIT_FORCE_MID_TUNE       = 6;
  localparam int BIT_PHASE_OFFSET_EN      = 5;
  localparam int CODE_MSB                 = 4;
  localparam int CODE_W                   = 5;

  // reset values
  localparam logic             RST_FIRST_STAGE_BYPASS   = 1'h0;
  localparam logic             RST_SECOND_STAGE_BYPASS  = 1'h0;
  localparam logic             RST_OSCILLATOR_RANGE_SEL = 1'h0;
  localparam logic             RST_VCXO_SLOPE_POLARITY  = 1'h0;
  localparam logic             RST_FORCE_MID_TUNE       = 1'h1;
  localparam logic             RST_PHASE_OFFSET_EN      = 1'h0;
  localparam logic [CODE_MSB:0] RST_FIRST_PUMP          = 5'h0F;
  localparam logic [CODE_MSB:0] RST_PHASE_OFFSET_STEPS  = 5'h00;
  localparam logic [CODE_MSB:0] RST_SECOND_PUMP         = 5'h06;

  // scaling of codes into physical units
  localparam logic [12:0] FIRST_PUMP_STEP_UA  = 13'h0032;
  localparam logic [12:0] SECOND_PUMP_STEP_UA = 13'h00C8;
  localparam logic [8:0]  OFFSET_STEP_DECIDEG = 9'h009;

  // serial frame: command byte (read flag, 7-bit address), then data byte
  localparam int         CMD_READ_BIT = 7;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [2:0] FIRST_BIT    = 3'h0;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_CMD  = 4'b0010,
    ST_DATA = 4'b0100,
    ST_DONE = 4'b1000
  } dpllc_state_type;

endpackage : dpllc_pkg

// >>> dpllc_host.sv
// dpllc_host: serial host model driving mode-0 register frames
`timescale 1ns/100ps

module dpllc_host
  import dpllc_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic miso_in,
  input  wire logic miso_oe_n_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      mosi_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // six clocks per phase keeps margin over the four-clock minimum
  task automatic half();
    repeat (6) @(posedge clk_in);
    #10;
  endtask : half

  // nbits below 16 cuts the frame short
  task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    half();
    cs_n_out = 1'b0;
    for (int i = 15; i >= 16 - nbits; i--) begin
      mosi_out = word[i];
      half();
      sclk_out = 1'b1;
      if (i < 8) rd = {rd[6:0], (miso_oe_n_in === 1'b0) ? miso_in : 1'bx};
      half();
      sclk_out = 1'b0;
    end
    // released line shows the inverse of its last bit
    mosi_out = ~mosi_out;
    half();
    cs_n_out = 1'b1;
    half();
  endtask : frame

  task automatic wr(input logic [6:0] addr, input logic [7:0] data, input int nbits);
    logic [7:0] d;
    d = data;
    if (addr == ADDR_SECOND_LOOP_PATH_CTRL) d[BIT_OSCILLATOR_RANGE_SEL] = 1'b0;
    frame({1'b0, addr, d}, nbits, d);
  endtask : wr

  task automatic rd(input logic [6:0] addr, output logic [7:0] data);
    frame({1'b1, addr, 8'h00}, 16, data);
  endtask : rd
endmodule : dpllc_host

// >>> dual_pll_control_registers_test.sv
// dual_pll_control_registers_test: self-checking bench for the loop control bank
`timescale 1ns/100ps

module dual_pll_control_registers_test;
  import dpllc_pkg::*;
  logic        clk_in;
  logic        srst_in;
  logic        sclk;
  logic        cs_n;
  logic        mosi;
  logic        miso;
  logic        oe_n;
  logic        fsb;
  logic        ssb;
  logic        osc;
  logic        pol;
  logic        fmt;
  logic        poe;
  logic [4:0]  p1;
  logic [4:0]  steps;
  logic [4:0]  p2;
  logic [10:0] ua1;
  logic [12:0] ua2;
  logic [8:0]  deg;
  logic [7:0]  rv;
  int          err_count;
  int          cmp_count;
  logic [6:0]  addrs [5] = '{7'h17, 7'h18, 7'h1C, 7'h1D, 7'h1E};
  logic [7:0]  masks [5] = '{8'h01, 8'h02, 8'hDF, 8'h3F, 8'h1F};

  dpllc_regs uut (.clk_in(clk_in), .srst_in(srst_in), .spi_sclk_in(sclk),
    .spi_cs_n_in(cs_n), .spi_mosi_in(mosi), .spi_miso_out(miso),
    .spi_miso_oe_n_out(oe_n), .first_stage_bypass_out(fsb),
    .second_stage_bypass_out(ssb), .oscillator_range_sel_out(osc),
    .vcxo_slope_polarity_out(pol), .force_mid_tune_out(fmt),
    .first_stage_pump_current_out(p1), .phase_offset_en_out(poe),
    .phase_offset_steps_out(steps), .second_stage_pump_current_out(p2),
    .first_stage_pump_ua_out(ua1), .second_stage_pump_ua_out(ua2),
    .phase_offset_decideg_out(deg));

  dpllc_host host (.clk_in(clk_in), .miso_in(miso), .miso_oe_n_in(oe_n),
    .sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi));

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic do_reset();
    srst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #10;
    srst_in = 1'b0;
    repeat (4) @(posedge clk_in);
    #10;
  endtask : do_reset

  task automatic t_reset();
    check(fsb, 1'b0, "bypass1");
    check(ssb, 1'b0, "bypass2");
    check(osc, 1'b0, "range");
    check(pol, 1'b0, "polarity");
    check(fmt, 1'b1, "forcemid");
    check(p1, 5'h0F, "pump1");
    check(ua1, 11'h320, "pump1 ua");
    check(poe, 1'b0, "offset en");
    check(steps, 5'h00, "steps");
    check(deg, 9'h000, "offset deg");
    check(p2, 5'h06, "pump2");
    check(ua2, 13'h0578, "pump2 ua");
    check({miso, oe_n}, 2'h1, "miso idle");
    host.rd(ADDR_FIRST_LOOP_TUNING_CTRL, rv);
    check(rv, 8'h4F, "tuning read");
    $display("test reset done");
  endtask : t_reset

  task automatic t_regs();
    for (int i = 0; i < 5; i++) begin
      host.wr(addrs[i], 8'hFF, 16);
      host.rd(addrs[i], rv);
      check(rv, masks[i], "all-ones readback");
    end
    check({fsb, ssb, osc, pol, fmt, poe}, 6'h37, "flags set");
    check(ua1, 11'h640, "pump1 max");
    check(deg, 9'h117, "offset max");
    check(ua2, 13'h1900, "pump2 max");
    for (int i = 0; i < 5; i++) begin
      // startup done: force-midpoint released
      host.wr(addrs[i], 8'h00, 16);
      host.rd(addrs[i], rv);
      check(rv, 8'h00, "zero readback");
    end
    check({fsb, ssb, pol, fmt, poe}, 5'h00, "flags clear");
    check(ua1, 11'h032, "pump1 min");
    check(ua2, 13'h00C8, "pump2 min");
    $display("test regs done");
  endtask : t_regs

  task automatic t_offset();
    // steps chosen above the jitter-derived floor of the reference
    host.wr(ADDR_FIRST_LOOP_PHASE_OFFSET, 8'h0A, 16);
    check({poe, steps}, 6'h0A, "offset off");
    check(deg, 9'h000, "no offset");
    host.wr(ADDR_FIRST_LOOP_PHASE_OFFSET, 8'h2A, 16);
    check(deg, 9'h05A, "offset on");
    $display("test offset done");
  endtask : t_offset

  task automatic t_abort();
    host.wr(ADDR_FIRST_LOOP_BYPASS_CTRL, 8'h01, 12);
    check(fsb, 1'b0, "aborted write");
    host.wr(7'h20, 8'hFF, 16);
    host.rd(7'h20, rv);
    check(rv, 8'h00, "unmapped read");
    host.rd(ADDR_FIRST_LOOP_BYPASS_CTRL, rv);
    check(rv, 8'h00, "bypass untouched");
    check({miso, oe_n}, 2'h1, "miso released");
    $display("test abort done");
  endtask : t_abort

  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    // about 30 frames of some 210 clocks each, with ample margin
    #3000000;
    err_count++;
    $display("BAD at %0t: watchdog expired", $time);
    wrap_up();
  end

  initial begin
    err_count = 0;
    cmp_count = 0;
    srst_in = 1'b1;
    do_reset();
    t_reset();
    t_regs();
    t_offset();
    t_abort();
    host.wr(ADDR_SECOND_LOOP_PUMP_CURRENT, 8'h1F, 16);
    do_reset();
    t_reset();
    wrap_up();
  end
endmodule : dual_pll_control_registers_test
